// ===== rtl/ies_irq_ctrl.sv
// Interrupt enable mask, pending flags and shared request line
`timescale 1ns/1ps

// Summary of operation
// - All sources leave on one line, maskable but for bit 3
// - Enable bit one permits, zero suppresses
// - Enabled activation latches flag, raises request
// - Request held until disable clears every flag
// - Bit 3 follows output shifter idle, unlatched
// - Bit 3 requests even when disabled
// - Disabled non-bit-3 flag reads as one
// - Events while disabled are dropped, not queued
// - Request is open drain, shareable line
// - Enable needs four cycles lead to latch
// - Disable needs two cycles lead; one-cycle window
// - Bit 3 drops only when shifter loads
// - Bit 4 fires on shifter load
// - Bit 6 fires on key code latch
module ies_irq_ctrl #(
    parameter int WIDTH = ies_pkg::SRC_WIDTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ies_pkg::ADDR_WIDTH-1:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [ies_pkg::DATA_WIDTH-1:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ies_pkg::ADDR_WIDTH-1:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [ies_pkg::DATA_WIDTH-1:0] rdata,
    output logic [1:0] rresp,
    // Event sources
    input wire logic [WIDTH-1:0] srcEvent,
    input wire logic serOutIdle,
    // Shared active-low request line, open drain
    input wire logic irqLineIn,
    output logic irqLineOut,
    output logic irqLineOe,
    // Local sticky interrupt
    output logic intOut
);
    import ies_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic [2:0] regSel(input logic [ADDR_WIDTH-1:0] addr);
        if (addr == OFF_ENABLE_MASK) begin
            regSel = 3'h1;
        end else if (addr == OFF_PENDING) begin
            regSel = 3'h2;
        end else if (addr == OFF_INT_STATUS) begin
            regSel = 3'h3;
        end else if (addr == OFF_INT_MASK) begin
            regSel = 3'h4;
        end else if (addr == OFF_LINE_STATUS) begin
            regSel = 3'h5;
        end else begin
            regSel = 3'h0;
        end
    endfunction

    localparam logic [2:0] SEL_NONE = 3'h0;
    localparam logic [2:0] SEL_ENABLE = 3'h1;
    localparam logic [2:0] SEL_PENDING = 3'h2;
    localparam logic [2:0] SEL_STATUS = 3'h3;
    localparam logic [2:0] SEL_IMASK = 3'h4;
    localparam logic [2:0] SEL_LINE = 3'h5;

    // Bit 3 is never latched; it mirrors the output shifter
    localparam logic [WIDTH-1:0] LATCHED_BITS = ~(WIDTH'(1) << BIT_SER_DONE);

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic awHave_q;
    logic wHave_q;
    logic [ADDR_WIDTH-1:0] awAddr_q;
    logic [DATA_WIDTH-1:0] wData_q;
    logic [3:0] wStrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic doWrite;
    logic [2:0] wrSel;
    logic wrLow;
    logic awTake;
    logic wTake;

    // Address and data are taken in either order, one write at a time
    assign awready = !awHave_q && !bvalid_q;
    assign wready = !wHave_q && !bvalid_q;
    // Each half is held until its partner arrives
    assign awTake = awvalid && awready;
    assign wTake = wvalid && wready;
    assign doWrite = awHave_q && wHave_q && !bvalid_q;
    assign wrSel = regSel(awAddr_q);
    assign wrLow = doWrite && wStrb_q[0];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            awHave_q <= 1'b0;
            awAddr_q <= '0;
        end else if (awTake) begin
            awHave_q <= 1'b1;
            awAddr_q <= awaddr;
        end else if (doWrite) begin
            awHave_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wHave_q <= 1'b0;
            wData_q <= '0;
            wStrb_q <= 4'h0;
        end else if (wTake) begin
            wHave_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
        end else if (doWrite) begin
            wHave_q <= 1'b0;
        end
    end

    // Unmapped writes answer SLVERR and change nothing
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid_q <= 1'b1;
            bresp_q <= (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    // ------------------------------------------------------------
    // Register write strobes
    // ------------------------------------------------------------
    logic wrEnable;
    logic wrStatus;
    logic wrIMask;

    // Only byte lane 0 carries register bits; other lanes change nothing
    assign wrEnable = wrLow && wrSel == SEL_ENABLE;
    assign wrStatus = wrLow && wrSel == SEL_STATUS;
    assign wrIMask = wrLow && wrSel == SEL_IMASK;

    // ------------------------------------------------------------
    // Enable mask
    // ------------------------------------------------------------
    logic [WIDTH-1:0] enMask_q;
    logic [WIDTH-1:0] enLate;
    logic [WIDTH-1:0] enEarly;
    logic [WIDTH-1:0] gate;

    // Cleared at reset so only bit 3 can pull the shared line until software enables
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            enMask_q <= WIDTH'(RST_ENABLE_MASK);
        end else if (wrEnable) begin
            enMask_q <= wData_q[WIDTH-1:0];
        end
    end

    // Enable must have stood three cycles: written four ahead
    ies_mask_delay #(
        .WIDTH(WIDTH),
        .DEPTH(ENABLE_DELAY)
    ) uEnableDelay (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .maskIn(enMask_q),
        .maskOut(enLate)
    );

    // Disable bites after one cycle, leaving the late window
    ies_mask_delay #(
        .WIDTH(WIDTH),
        .DEPTH(DISABLE_DELAY)
    ) uDisableDelay (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .maskIn(enMask_q),
        .maskOut(enEarly)
    );

    assign gate = enLate & enEarly;

    // ------------------------------------------------------------
    // Pending latches
    // ------------------------------------------------------------
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] setBits;
    logic [WIDTH-1:0] pendRead;
    logic serIdle_q;
    logic serDoneRise;
    logic request;

    // Sources gated off are simply lost; nothing waits for enable
    assign setBits = srcEvent & gate & LATCHED_BITS;

    // A late-window event still lands, then clears once disabled
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            latch_q <= '0;
        end else begin
            latch_q <= (latch_q & enMask_q) | setBits;
        end
    end

    // Reset to the idle level so no false completion follows reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            serIdle_q <= 1'b1;
        end else begin
            serIdle_q <= serOutIdle;
        end
    end

    assign serDoneRise = serOutIdle && !serIdle_q;

    // Disabled flags read as one; bit 3 tracks the shifter live
    always_comb begin
        pendRead = latch_q | ~enMask_q;
        pendRead[BIT_SER_DONE] = serOutIdle;
    end

    // Bit 3 requests regardless of its enable, as a software trigger
    assign request = |latch_q || serOutIdle;

    // Only pulls low; other devices share the same wire
    assign irqLineOut = 1'b0;
    assign irqLineOe = request;

    // ------------------------------------------------------------
    // Sticky event status for the local interrupt
    // ------------------------------------------------------------
    logic [WIDTH-1:0] stEvent;
    logic [WIDTH-1:0] stClear;
    logic [WIDTH-1:0] stStatus;
    logic [WIDTH-1:0] stMask;

    // Local copy records each bit 3 completion as an edge
    always_comb begin
        stEvent = setBits;
        stEvent[BIT_SER_DONE] = serDoneRise;
    end

    assign stClear = wrStatus ? wData_q[WIDTH-1:0] : '0;

    ies_sticky_irq #(
        .WIDTH(WIDTH)
    ) uSticky (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .eventIn(stEvent),
        .clearBits(stClear),
        .maskWrite(wrIMask),
        .maskData(wData_q[WIDTH-1:0]),
        .status(stStatus),
        .mask(stMask),
        .irqOut(intOut)
    );

    // ------------------------------------------------------------
    // Line status
    // ------------------------------------------------------------
    logic [DATA_WIDTH-1:0] lineWord;

    // The wire may be low from other devices while this block is quiet
    always_comb begin
        lineWord = '0;
        lineWord[BIT_LINE_OWN] = request;
        lineWord[BIT_LINE_LOW] = !irqLineIn;
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic rvalid_q;
    logic [DATA_WIDTH-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic [2:0] rdSel;
    logic [DATA_WIDTH-1:0] rdMux;

    assign arready = !rvalid_q;
    assign rdSel = regSel(araddr);

    // Reads have no side effect; the enable mask is write only
    always_comb begin
        rdMux = '0;
        if (rdSel == SEL_PENDING) begin
            rdMux[WIDTH-1:0] = pendRead;
        end else if (rdSel == SEL_STATUS) begin
            rdMux[WIDTH-1:0] = stStatus;
        end else if (rdSel == SEL_IMASK) begin
            rdMux[WIDTH-1:0] = stMask;
        end else if (rdSel == SEL_LINE) begin
            rdMux = lineWord;
        end
    end

    // Unmapped reads answer SLVERR with zero data
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rdMux;
            rresp_q <= (rdSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

endmodule

// ===== rtl/ies_pkg.sv
// Shared constants of the interrupt enable and status block
package ies_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_ENABLE_MASK = 8'h00;
    localparam logic [7:0] OFF_PENDING = 8'h04;
    localparam logic [7:0] OFF_INT_STATUS = 8'h08;
    localparam logic [7:0] OFF_INT_MASK = 8'h0c;
    localparam logic [7:0] OFF_LINE_STATUS = 8'h10;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int SRC_WIDTH = 8;
    localparam int BIT_SER_DONE = 3;
    localparam int BIT_SER_READY = 4;
    localparam int BIT_KEYBOARD = 6;
    localparam int BIT_LINE_OWN = 0;
    localparam int BIT_LINE_LOW = 1;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ENABLE_MASK = 8'h00;
    localparam logic [7:0] RST_INT_STATUS = 8'h00;
    localparam logic [7:0] RST_INT_MASK = 8'h00;

    // ------------------------------------------------------------
    // Timing: leads in device cycles before a source activates
    // ------------------------------------------------------------
    localparam int ENABLE_LEAD_CYCLES = 4;
    localparam int DISABLE_LEAD_CYCLES = 2;
    localparam int ENABLE_DELAY = ENABLE_LEAD_CYCLES - 1;
    localparam int DISABLE_DELAY = DISABLE_LEAD_CYCLES - 1;

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== rtl/ies_mask_delay.sv
// Delayed copy of the enable mask for write-to-effect timing
`timescale 1ns/1ps
module ies_mask_delay #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 3
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] maskIn,
    output logic [WIDTH-1:0] maskOut
);

    logic [WIDTH-1:0] stage_q [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_q[i] <= '0;
            end
        end else begin
            stage_q[0] <= maskIn;
            for (int i = 1; i < DEPTH; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign maskOut = stage_q[DEPTH-1];

endmodule

// ===== rtl/ies_sticky_irq.sv
// Sticky event status with write-one-to-clear and mask gating
`timescale 1ns/1ps
module ies_sticky_irq #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] eventIn,
    input wire logic [WIDTH-1:0] clearBits,
    input wire logic maskWrite,
    input wire logic [WIDTH-1:0] maskData,
    output logic [WIDTH-1:0] status,
    output logic [WIDTH-1:0] mask,
    output logic irqOut
);
    import ies_pkg::*;

    logic [WIDTH-1:0] status_q;
    logic [WIDTH-1:0] mask_q;

    // Set beats clear so an event on the clearing edge is kept
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            status_q <= RST_INT_STATUS[WIDTH-1:0];
        end else begin
            status_q <= (status_q & ~clearBits) | eventIn;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mask_q <= RST_INT_MASK[WIDTH-1:0];
        end else if (maskWrite) begin
            mask_q <= maskData;
        end
    end

    assign status = status_q;
    assign mask = mask_q;
    assign irqOut = |(status_q & mask_q);

endmodule

// ===== verification/ies_cpu_model.sv
// Processor model sharing the pulled-up request line
`timescale 1ns/1ps
module ies_cpu_model #(
    parameter int ACK_DELAY = 3
) (
    input wire logic clk_sys,
    input wire logic irqLineOe,
    input wire logic otherPull,
    input wire logic irqMasked,
    output logic irqLineIn,
    output logic ackActive
);
    int lowCnt = 0;
    int ackCnt = 0;
    // Pull-up wins only while no party pulls low
    assign irqLineIn = !(irqLineOe || otherPull);
    assign ackActive = ackCnt > 0;
    // Masked processor never acts on a late request
    always @(posedge clk_sys) begin
        lowCnt <= (!irqLineIn && !irqMasked) ? lowCnt + 1 : 0;
        if (ackCnt > 0) begin
            ackCnt <= ackCnt - 1;
        end else if (lowCnt == ACK_DELAY) begin
            ackCnt <= 7;
        end
    end
endmodule

// ===== verification/ies_irq_ctrl_chk.sv
// Assertion checker for the interrupt enable and status block
`timescale 1ns/1ps
module ies_irq_ctrl_chk #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [ies_pkg::DATA_WIDTH-1:0] rdata,
    input wire logic [WIDTH-1:0] srcEvent,
    input wire logic serOutIdle,
    input wire logic irqLineOut,
    input wire logic irqLineOe
);
    import ies_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic wTake;
    logic evAny;
    assign wTake = wvalid && wready;
    // Bit 3 input is ignored by the block
    assign evAny = |(srcEvent & ~(WIDTH'(1) << BIT_SER_DONE));
    AST_LINE_LOW_ONLY: assert property (!irqLineOut)
        else $error("request line driven high");
    AST_IDLE_REQ: assert property (serOutIdle |-> irqLineOe)
        else $error("idle shifter without request");
    AST_NO_SPURIOUS: assert property (!irqLineOe && !evAny |=> !irqLineOe || serOutIdle)
        else $error("request without event");
    // Window covers the late latch after a disable
    AST_REQ_HELD: assert property (!wTake [*5] ##0 (irqLineOe && !serOutIdle) |=> irqLineOe)
        else $error("request dropped without a write");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer not held");
    // Both halves taken at one edge: the answer rises two edges later
    AST_B_AFTER: assert property (awvalid && awready && wTake |=> ##1 bvalid)
        else $error("write answer missing");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer not held");
    AST_R_AFTER: assert property (arvalid && arready |=> rvalid)
        else $error("read answer missing");
    AST_AR_STALL: assert property (rvalid |-> !arready)
        else $error("read taken while answer pending");
endmodule
bind ies_irq_ctrl ies_irq_ctrl_chk #(.WIDTH(WIDTH)) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .srcEvent(srcEvent), .serOutIdle(serOutIdle),
    .irqLineOut(irqLineOut), .irqLineOe(irqLineOe)
);

// ===== verification/tb_ies_irq_ctrl.sv
// Self-checking bench of the interrupt enable and status block
`timescale 1ns/1ps
module tb_ies_irq_ctrl;
    import ies_pkg::*;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, irqLineIn, irqLineOut, irqLineOe, intOut;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, srcEvent = 8'h00, m;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic serOutIdle = 1'h0, otherPull = 1'h0, cpuMasked = 1'h1, ackActive;
    int nFail = 0, samplesChecked = 0, cycles = 0;
    always #4 clk_sys = ~clk_sys;
    ies_irq_ctrl dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .srcEvent(srcEvent),
        .serOutIdle(serOutIdle), .irqLineIn(irqLineIn), .irqLineOut(irqLineOut),
        .irqLineOe(irqLineOe), .intOut(intOut)
    );
    ies_cpu_model cpu (
        .clk_sys(clk_sys), .irqLineOe(irqLineOe), .otherPull(otherPull),
        .irqMasked(cpuMasked), .irqLineIn(irqLineIn), .ackActive(ackActive)
    );
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            nFail++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nFail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] rsp(input logic [7:0] a);
        return (a > OFF_LINE_STATUS) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Pulse ev so that it is sampled n edges after the write is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n,
            input logic [7:0] ev);
        bit bd = 0;
        int j = 0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!bd || j <= n) begin
            @(posedge clk_sys);
            j++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            srcEvent <= (j == n) ? ev : 8'h00;
            if (bvalid && bready) begin
                bd = 1;
                bready <= 1'h0;
                chk(32'(bresp), rsp(a));
            end
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rready <= 1'h0;
        chk(32'(rresp), rsp(a));
        if (a <= OFF_LINE_STATUS) chk(rdata, 32'(e));
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'h1;
        rc(OFF_ENABLE_MASK, 8'h00);
        rc(OFF_PENDING, 8'hf7);
        wr(OFF_PENDING, 32'h0, 0, 8'h00);
        rc(OFF_PENDING, 8'hf7);
        rc(8'h40, 8'h00);
        wr(8'h40, 32'h0, 0, 8'h00);
        wr(OFF_INT_MASK, 32'hf7, 0, 8'h00);
        for (int b = 0; b < 8; b++) begin
            if (b == BIT_SER_DONE) continue;
            m = 8'h01 << b;
            wr(OFF_INT_STATUS, 32'hff, 0, 8'h00);
            wr(OFF_ENABLE_MASK, 32'(m), 4, m);
            cyc(2);
            chk(32'(irqLineOe), 32'h0);
            rc(OFF_INT_STATUS, 8'h00);
            wr(OFF_ENABLE_MASK, 32'h0, 3, m);
            cyc(2);
            rc(OFF_INT_STATUS, 8'h00);
            wr(OFF_ENABLE_MASK, 32'(m), 0, 8'h00);
            cyc(4);
            wr(OFF_ENABLE_MASK, 32'h0, 2, m);
            cyc(4);
            rc(OFF_INT_STATUS, m);
            chk(32'(irqLineOe), 32'h0);
            chk(32'(intOut), 32'h1);
            wr(OFF_INT_STATUS, 32'(m), 0, 8'h00);
            cyc(1);
            chk(32'(intOut), 32'h0);
            wr(OFF_ENABLE_MASK, 32'(m), 5, m);
            cyc(8);
            chk(32'(irqLineOe), 32'h1);
            rc(OFF_PENDING, 8'hf7);
            rc(OFF_LINE_STATUS, 8'h03);
            wr(OFF_ENABLE_MASK, 32'h0, 0, 8'h00);
            cyc(3);
            chk(32'(irqLineOe), 32'h0);
        end
        wr(OFF_INT_STATUS, 32'hff, 0, 8'h00);
        serOutIdle <= 1'h1;
        cyc(2);
        chk(32'(irqLineOe), 32'h1);
        rc(OFF_PENDING, 8'hff);
        rc(OFF_INT_STATUS, 8'h08);
        chk(32'(intOut), 32'h0);
        cpuMasked <= 1'h0;
        cyc(6);
        chk(32'(ackActive), 32'h1);
        cpuMasked <= 1'h1;
        serOutIdle <= 1'h0;
        cyc(2);
        chk(32'(irqLineOe), 32'h0);
        otherPull <= 1'h1;
        rc(OFF_LINE_STATUS, 8'h02);
        // Second reset with the shifter idle: no false completion after it
        otherPull <= 1'h0;
        serOutIdle <= 1'h1;
        rst_n <= 1'h0;
        cyc(3);
        rst_n <= 1'h1;
        rc(OFF_INT_STATUS, 8'h00);
        rc(OFF_PENDING, 8'hff);
        chk(32'(irqLineOe), 32'h1);
        wrap_up();
    end
endmodule
